// file: rtl/dsau_top.sv
// Dual setpoint alarm unit with APB registers and digit editor
// Behaviour
// - Enable bit turns a channel on or off, other settings kept.
// - Two independent channels, each picks rate or total source.
// - Alarm on value equal to setpoint; high alarm also above it, low alarm also below it.
// - Changing source resets channel settings to defaults and disables it.
// - Rate setpoints are six decimal digits, 000000 to 999999.
// - Total setpoints are eight decimal digits, 00000000 to 99999999.
// - Each channel high or low, any mix allowed.
// - Idle contact open or closed as selected; alarm gives the opposite.
// - Hysteresis only on rate channels, in rate units.
// - High rate alarm sets at setpoint, clears below setpoint minus hysteresis.
// - Output delayed by whole seconds, zero to 3600.
// - Annunciator flashes during delay, then steady with output active.
// - Accept button works only when silence time nonzero.
// - Accept silences output for silence time, annunciator flashing.
// - Flash option alternates display with channel tag during alarm.
// - Digit by digit editing with up, down, next and enter.
// - Direct setpoint menu guarded by its own access code.
// - Compare twice per second independent of display refresh.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
module dsau_top #(
    parameter int unsigned TICK_CYCLES = dsau_pkg::TICK_CYC
) (
    input logic pclk,
    input logic presetn,
    input logic clk_en,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic [31:0] rate_value,
    input logic [31:0] total_value,
    input logic btn_accept,
    input logic btn_up,
    input logic btn_down,
    input logic btn_next,
    input logic btn_enter,
    input logic edit_start,
    input logic edit_ch,
    input logic edit_hys,
    input logic edit_direct,
    input logic [15:0] menu_code,
    output logic edit_active,
    output logic [2:0] edit_digit,
    output logic [31:0] edit_value,
    output logic [1:0] alarm_out,
    output logic [1:0] annunciator,
    output logic [1:0] show_tag
);
    logic [1:0][4:0] cfg_ff, nxt_cfg;
    logic [1:0][31:0] sp_ff, nxt_sp, hys_ff, nxt_hys;
    logic [1:0][11:0] dly_ff, nxt_dly, sil_ff, nxt_sil, tmr_ff, nxt_tmr;
    logic menu_en_ff, nxt_menu_en;
    logic [15:0] code_ff, nxt_code;
    logic ed_act_ff, nxt_ed_act, ed_ch_ff, nxt_ed_ch, ed_hys_ff, nxt_ed_hys;
    logic [2:0] ed_dig_ff, nxt_ed_dig;
    logic [31:0] ed_val_ff, nxt_ed_val;
    logic [22:0] tick_cnt_ff, nxt_tick_cnt;
    logic half_ff, nxt_half, phase_ff, nxt_phase;
    logic [1:0] cond_ff, nxt_cond, out_ff, nxt_out, ann_ff, nxt_ann, tag_ff, nxt_tag;
    dsau_pkg::dsau_state_e st_ff [2];
    dsau_pkg::dsau_state_e nxt_st [2];
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic [1:0] go;
    logic sec_tick;
    logic wr_en;

    assign sec_tick = half_ff && phase_ff;
    assign wr_en = psel && penable && pwrite && pready_ff;
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign edit_active = ed_act_ff;
    assign edit_digit = ed_dig_ff;
    assign edit_value = ed_val_ff;
    assign alarm_out = out_ff;
    assign annunciator = ann_ff;
    assign show_tag = tag_ff;

    // APB answer: one wait state, read data registered together with pready
    always_comb
    begin
        logic [3:0] d;
        d = dsau_pkg::dsau_dec(paddr);
        nxt_pready = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata = prdata_ff;
        if (psel && penable && !pready_ff)
        begin
            nxt_pready = 1'b1;
            nxt_pslverr = (d[2:0] == dsau_pkg::IDX_NONE);
            unique case (d[2:0])
                dsau_pkg::IDX_CFG: nxt_prdata = {27'h0, cfg_ff[d[3]]};
                dsau_pkg::IDX_SP: nxt_prdata = sp_ff[d[3]];
                dsau_pkg::IDX_HYS: nxt_prdata = hys_ff[d[3]];
                dsau_pkg::IDX_DLY: nxt_prdata = {20'h0, dly_ff[d[3]]};
                dsau_pkg::IDX_SIL: nxt_prdata = {20'h0, sil_ff[d[3]]};
                dsau_pkg::IDX_STAT: nxt_prdata = {22'h0, tmr_ff[d[3]][5:0], st_ff[d[3]]} | {31'h0, cond_ff[d[3]]} << 10;
                dsau_pkg::IDX_MENU: nxt_prdata = {31'h0, menu_en_ff};
                dsau_pkg::IDX_NONE: nxt_prdata = 32'h0;
            endcase
        end
    end

    // Compare tick every half second
    always_comb
    begin
        nxt_tick_cnt = tick_cnt_ff + 23'h1;
        nxt_half = 1'b0;
        nxt_phase = phase_ff ^ half_ff;
        if (tick_cnt_ff == 23'(TICK_CYCLES - 1))
        begin
            nxt_tick_cnt = 23'h0;
            nxt_half = 1'b1;
        end
    end

    // Configuration writes and front panel digit editor
    always_comb
    begin
        logic [3:0] d;
        logic c;
        logic rate;
        logic [3:0] nib;
        logic [2:0] last;
        logic permit;
        d = dsau_pkg::dsau_dec(paddr);
        c = d[3];
        rate = !cfg_ff[ed_ch_ff][dsau_pkg::CFG_TOTAL];
        nib = ed_val_ff[ed_dig_ff*4+:4];
        last = (rate || ed_hys_ff) ? dsau_pkg::LAST_RATE : dsau_pkg::LAST_TOTAL;
        permit = !edit_direct || (menu_en_ff && !edit_hys
                 && (code_ff == dsau_pkg::CODE_RST || code_ff == menu_code));
        nxt_cfg = cfg_ff;
        nxt_sp = sp_ff;
        nxt_hys = hys_ff;
        nxt_dly = dly_ff;
        nxt_sil = sil_ff;
        nxt_menu_en = menu_en_ff;
        nxt_code = code_ff;
        nxt_ed_act = ed_act_ff;
        nxt_ed_ch = ed_ch_ff;
        nxt_ed_hys = ed_hys_ff;
        nxt_ed_dig = ed_dig_ff;
        nxt_ed_val = ed_val_ff;
        if (wr_en)
        begin
            unique case (d[2:0])
                dsau_pkg::IDX_CFG:
                begin
                    if (pwdata[dsau_pkg::CFG_TOTAL] != cfg_ff[c][dsau_pkg::CFG_TOTAL])
                    begin
                        nxt_cfg[c] = dsau_pkg::CFG_RST;
                        nxt_cfg[c][dsau_pkg::CFG_TOTAL] = pwdata[dsau_pkg::CFG_TOTAL];
                        nxt_sp[c] = dsau_pkg::VAL_RST;
                        nxt_hys[c] = dsau_pkg::VAL_RST;
                        nxt_dly[c] = dsau_pkg::TIME_RST;
                        nxt_sil[c] = dsau_pkg::TIME_RST;
                    end
                    else
                    begin
                        nxt_cfg[c] = pwdata[4:0];
                    end
                end
                dsau_pkg::IDX_SP:
                begin
                    if (dsau_pkg::dsau_bcd_ok(pwdata, !cfg_ff[c][dsau_pkg::CFG_TOTAL]))
                    begin
                        nxt_sp[c] = pwdata;
                    end
                end
                dsau_pkg::IDX_HYS:
                begin
                    if (!cfg_ff[c][dsau_pkg::CFG_TOTAL] && dsau_pkg::dsau_bcd_ok(pwdata, 1'b1))
                    begin
                        nxt_hys[c] = pwdata;
                    end
                end
                dsau_pkg::IDX_DLY:
                begin
                    if (pwdata <= {20'h0, dsau_pkg::DLY_MAX})
                    begin
                        nxt_dly[c] = pwdata[11:0];
                    end
                end
                dsau_pkg::IDX_SIL:
                begin
                    if (pwdata[31:12] == 20'h0)
                    begin
                        nxt_sil[c] = pwdata[11:0];
                    end
                end
                dsau_pkg::IDX_MENU:
                begin
                    nxt_menu_en = pwdata[0];
                    if (dsau_pkg::dsau_bcd_ok({16'h0, pwdata[31:16]}, 1'b0))
                    begin
                        nxt_code = pwdata[31:16];
                    end
                end
                dsau_pkg::IDX_STAT, dsau_pkg::IDX_NONE:
                begin
                end
            endcase
        end
        if (!ed_act_ff)
        begin
            if (edit_start && permit && !(edit_hys && cfg_ff[edit_ch][dsau_pkg::CFG_TOTAL]))
            begin
                nxt_ed_act = 1'b1;
                nxt_ed_ch = edit_ch;
                nxt_ed_hys = edit_hys;
                nxt_ed_dig = 3'h0;
                nxt_ed_val = edit_hys ? hys_ff[edit_ch] : sp_ff[edit_ch];
            end
        end
        else if (btn_enter)
        begin
            nxt_ed_act = 1'b0;
            if (ed_hys_ff)
            begin
                nxt_hys[ed_ch_ff] = rate ? ed_val_ff : hys_ff[ed_ch_ff];
            end
            else
            begin
                nxt_sp[ed_ch_ff] = rate ? {8'h00, ed_val_ff[23:0]} : ed_val_ff;
            end
        end
        else if (btn_up)
        begin
            nxt_ed_val[ed_dig_ff*4+:4] = (nib == 4'h9) ? 4'h0 : nib + 4'h1;
        end
        else if (btn_down)
        begin
            nxt_ed_val[ed_dig_ff*4+:4] = (nib == 4'h0) ? 4'h9 : nib - 4'h1;
        end
        else if (btn_next)
        begin
            nxt_ed_dig = (ed_dig_ff >= last) ? 3'h0 : ed_dig_ff + 3'h1;
        end
    end

    // Per channel compare, sequencing and indications
    always_comb
    begin
        logic [31:0] v;
        logic [31:0] h;
        v = 32'h0;
        h = 32'h0;
        for (int i = 0; i < 2; i++)
        begin
            v = cfg_ff[i][dsau_pkg::CFG_TOTAL] ? total_value : rate_value;
            h = cfg_ff[i][dsau_pkg::CFG_TOTAL] ? dsau_pkg::VAL_RST : hys_ff[i];
            nxt_cond[i] = cond_ff[i];
            if (!cfg_ff[i][dsau_pkg::CFG_EN])
            begin
                nxt_cond[i] = 1'b0;
            end
            else if (half_ff && !cfg_ff[i][dsau_pkg::CFG_LOW])
            begin
                nxt_cond[i] = cond_ff[i] ? !(dsau_pkg::dsau_bcd_add(v, h) < {4'h0, sp_ff[i]})
                                         : (v >= sp_ff[i]);
            end
            else if (half_ff)
            begin
                nxt_cond[i] = cond_ff[i] ? !({4'h0, v} > dsau_pkg::dsau_bcd_add(sp_ff[i], h))
                                         : (v <= sp_ff[i]);
            end
            nxt_st[i] = st_ff[i];
            nxt_tmr[i] = tmr_ff[i];
            unique case (st_ff[i])
                dsau_pkg::ST_IDLE:
                begin
                    if (go[i])
                    begin
                        nxt_st[i] = (dly_ff[i] == dsau_pkg::TIME_RST) ? dsau_pkg::ST_ALARM : dsau_pkg::ST_DELAY;
                        nxt_tmr[i] = dly_ff[i];
                    end
                end
                dsau_pkg::ST_DELAY, dsau_pkg::ST_SILENT:
                begin
                    if (!go[i])
                    begin
                        nxt_st[i] = dsau_pkg::ST_IDLE;
                        nxt_tmr[i] = dsau_pkg::TIME_RST;
                    end
                    else if (sec_tick && tmr_ff[i] <= 12'h001)
                    begin
                        nxt_st[i] = dsau_pkg::ST_ALARM;
                        nxt_tmr[i] = dsau_pkg::TIME_RST;
                    end
                    else if (sec_tick)
                    begin
                        nxt_tmr[i] = tmr_ff[i] - 12'h001;
                    end
                end
                dsau_pkg::ST_ALARM:
                begin
                    if (!go[i])
                    begin
                        nxt_st[i] = dsau_pkg::ST_IDLE;
                    end
                    else if (btn_accept && sil_ff[i] != dsau_pkg::TIME_RST)
                    begin
                        nxt_st[i] = dsau_pkg::ST_SILENT;
                        nxt_tmr[i] = sil_ff[i];
                    end
                end
            endcase
            nxt_out[i] = (nxt_st[i] == dsau_pkg::ST_ALARM) ^ cfg_ff[i][dsau_pkg::CFG_NC];
            nxt_ann[i] = (nxt_st[i] == dsau_pkg::ST_ALARM) || (nxt_st[i] != dsau_pkg::ST_IDLE && phase_ff);
            nxt_tag[i] = cfg_ff[i][dsau_pkg::CFG_FLASH] && nxt_st[i] == dsau_pkg::ST_ALARM && phase_ff;
        end
    end

    assign go = cond_ff & {cfg_ff[1][dsau_pkg::CFG_EN], cfg_ff[0][dsau_pkg::CFG_EN]};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_ff <= {2{dsau_pkg::CFG_RST}};
            sp_ff <= {2{dsau_pkg::VAL_RST}};
            hys_ff <= {2{dsau_pkg::VAL_RST}};
            dly_ff <= {2{dsau_pkg::TIME_RST}};
            sil_ff <= {2{dsau_pkg::TIME_RST}};
            tmr_ff <= {2{dsau_pkg::TIME_RST}};
            menu_en_ff <= 1'b0;
            code_ff <= dsau_pkg::CODE_RST;
            ed_act_ff <= 1'b0;
            ed_ch_ff <= 1'b0;
            ed_hys_ff <= 1'b0;
            ed_dig_ff <= 3'h0;
            ed_val_ff <= dsau_pkg::VAL_RST;
            tick_cnt_ff <= 23'h0;
            half_ff <= 1'b0;
            phase_ff <= 1'b0;
            cond_ff <= 2'h0;
            out_ff <= 2'h0;
            ann_ff <= 2'h0;
            tag_ff <= 2'h0;
            st_ff <= '{default: dsau_pkg::ST_IDLE};
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end
        else if (clk_en)
        begin
            cfg_ff <= nxt_cfg;
            sp_ff <= nxt_sp;
            hys_ff <= nxt_hys;
            dly_ff <= nxt_dly;
            sil_ff <= nxt_sil;
            tmr_ff <= nxt_tmr;
            menu_en_ff <= nxt_menu_en;
            code_ff <= nxt_code;
            ed_act_ff <= nxt_ed_act;
            ed_ch_ff <= nxt_ed_ch;
            ed_hys_ff <= nxt_ed_hys;
            ed_dig_ff <= nxt_ed_dig;
            ed_val_ff <= nxt_ed_val;
            tick_cnt_ff <= nxt_tick_cnt;
            half_ff <= nxt_half;
            phase_ff <= nxt_phase;
            cond_ff <= nxt_cond;
            out_ff <= nxt_out;
            ann_ff <= nxt_ann;
            tag_ff <= nxt_tag;
            st_ff <= nxt_st;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    default clocking cb @(posedge pclk iff clk_en); endclocking
    default disable iff (!presetn);

    sequence s_delay_start;
        st_ff[0] == dsau_pkg::ST_IDLE && go[0] && dly_ff[0] != 12'h000;
    endsequence
    sequence s_accept;
        st_ff[0] == dsau_pkg::ST_ALARM && go[0] && btn_accept;
    endsequence

    a_rate_sp_digits: assert property (!cfg_ff[0][1] |-> sp_ff[0][31:24] == 8'h00)
        else $error("rate setpoint wider than six digits");
    a_sp_decimal: assert property (dsau_pkg::dsau_bcd_ok(sp_ff[0], 1'b0))
        else $error("setpoint holds a non decimal digit");
    a_src_reset: assert property (wr_en && paddr == 8'h00 && pwdata[1] != cfg_ff[0][1]
        |=> !cfg_ff[0][0] && sp_ff[0] == 32'h0 && dly_ff[0] == 12'h000)
        else $error("source change did not reset channel");
    a_total_no_hys: assert property (cfg_ff[0][1] |-> hys_ff[0] == 32'h0)
        else $error("total channel holds hysteresis");
    a_high_set: assert property (half_ff && cfg_ff[0][0] && !cfg_ff[0][2] && !cond_ff[0]
        && rate_value >= sp_ff[0] && !cfg_ff[0][1] |=> cond_ff[0])
        else $error("high alarm not raised at setpoint");
    a_low_set: assert property (half_ff && cfg_ff[0][0] && cfg_ff[0][2] && !cond_ff[0]
        && (cfg_ff[0][1] ? total_value : rate_value) <= sp_ff[0] |=> cond_ff[0])
        else $error("low alarm not raised at setpoint");
    a_delay_enter: assert property (s_delay_start |=> st_ff[0] == dsau_pkg::ST_DELAY
        && tmr_ff[0] == $past(dly_ff[0]))
        else $error("delay not started with programmed time");
    a_cancel_idle: assert property (st_ff[0] != dsau_pkg::ST_IDLE && !go[0]
        |=> st_ff[0] == dsau_pkg::ST_IDLE ##1 !ann_ff[0])
        else $error("lost condition not cancelled");
    a_silence_go: assert property (s_accept ##0 sil_ff[0] != 12'h000 |=> st_ff[0] == dsau_pkg::ST_SILENT
        ##1 out_ff[0] == $past(cfg_ff[0][3]))
        else $error("accept did not silence output");
    a_no_accept: assert property (s_accept ##0 sil_ff[0] == 12'h000 |=> st_ff[0] == dsau_pkg::ST_ALARM)
        else $error("accept acted with zero silence time");
    a_steady_ann: assert property (st_ff[0] == dsau_pkg::ST_ALARM && go[0] && !btn_accept |=> ann_ff[0]
        && out_ff[0] != $past(cfg_ff[0][3]))
        else $error("active alarm not steady");
    a_direct_guard: assert property (!ed_act_ff && edit_start && edit_direct && !menu_en_ff |=> !ed_act_ff)
        else $error("direct menu opened while disabled");
    a_tick_space: assert property (half_ff |=> !half_ff)
        else $error("compare tick too frequent");
endmodule : dsau_top

// file: rtl/dsau_pkg.sv
// Shared constants, types and helpers of the dual setpoint alarm unit
package dsau_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TICK_MS = 500;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam logic [7:0] CH_STRIDE = 8'h20;
    localparam logic [7:0] OFF_MENU = 8'h40;
    localparam logic [2:0] IDX_CFG = 3'h0;
    localparam logic [2:0] IDX_SP = 3'h1;
    localparam logic [2:0] IDX_HYS = 3'h2;
    localparam logic [2:0] IDX_DLY = 3'h3;
    localparam logic [2:0] IDX_SIL = 3'h4;
    localparam logic [2:0] IDX_STAT = 3'h5;
    localparam logic [2:0] IDX_MENU = 3'h6;
    localparam logic [2:0] IDX_NONE = 3'h7;
    localparam int unsigned CFG_EN = 0;
    localparam int unsigned CFG_TOTAL = 1;
    localparam int unsigned CFG_LOW = 2;
    localparam int unsigned CFG_NC = 3;
    localparam int unsigned CFG_FLASH = 4;
    localparam logic [4:0] CFG_RST = 5'h00;
    localparam logic [31:0] VAL_RST = 32'h0000_0000;
    localparam logic [11:0] TIME_RST = 12'h000;
    localparam logic [11:0] DLY_MAX = 12'he10;
    localparam logic [15:0] CODE_RST = 16'h0000;
    localparam logic [2:0] LAST_RATE = 3'h5;
    localparam logic [2:0] LAST_TOTAL = 3'h7;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DELAY = 4'b0010,
        ST_ALARM = 4'b0100,
        ST_SILENT = 4'b1000
    } dsau_state_e;

    // Eight digit decimal sum with carry digit
    function automatic logic [35:0] dsau_bcd_add(input logic [31:0] a, input logic [31:0] b);
        logic [4:0] s;
        logic c;
        logic [35:0] r;
        c = 1'b0;
        r = 36'h0;
        for (int i = 0; i < 8; i++)
        begin
            s = {1'b0, a[i*4+:4]} + {1'b0, b[i*4+:4]} + {4'h0, c};
            c = (s > 5'h09);
            if (c)
            begin
                s = s + 5'h06;
            end
            r[i*4+:4] = s[3:0];
        end
        r[35:32] = {3'h0, c};
        return r;
    endfunction : dsau_bcd_add

    // Decimal digits only; six digits when rate
    function automatic logic dsau_bcd_ok(input logic [31:0] v, input logic rate);
        logic ok;
        ok = !(rate && v[31:24] != 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            if (v[i*4+:4] > 4'h9)
            begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : dsau_bcd_ok

    // Register decode: channel bit and register index
    function automatic logic [3:0] dsau_dec(input logic [7:0] a);
        logic [3:0] r;
        r = {1'b0, IDX_NONE};
        if (a == OFF_MENU)
        begin
            r = {1'b0, IDX_MENU};
        end
        else if (a < OFF_MENU && a[1:0] == 2'h0 && a[4:2] <= IDX_STAT)
        begin
            r = {a[5], a[4:2]};
        end
        return r;
    endfunction : dsau_dec
endpackage : dsau_pkg

// file: testbench/dsau_load.sv
// Load circuit switched by the two alarm contacts
`timescale 1ns/1ps
module dsau_load (
    input logic [1:0] contact,
    output logic [1:0] load_on
);
    // Current flows only while a contact is closed
    always_comb
    begin
        load_on = contact;
    end
endmodule : dsau_load

// file: testbench/tb_top.sv
// Self-checking bench of the dual setpoint alarm unit
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; $display("BAD %0t %h %h", $time, a, e); end end
module tb_top;
    localparam int TK = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rate_v = 32'h0;
    logic [31:0] tot_v = 32'h0;
    logic [6:0] keys = 7'h00;
    logic edit_direct = 1'b0;
    logic [15:0] code = 16'h0;
    logic [31:0] prdata, edit_value, rd, sp, tv, e;
    logic pready, pslverr, edit_active, er;
    logic [2:0] edit_digit;
    logic [1:0] alarm_out, annunciator, show_tag, load_on;
    int failures = 0;
    int comparisons = 0;
    int seed = 17;
    int n;
    dsau_top #(.TICK_CYCLES(TK)) i_dsau_top (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rate_value(rate_v), .total_value(tot_v), .btn_accept(keys[0]), .btn_up(keys[1]),
        .btn_down(keys[2]), .btn_next(keys[3]), .btn_enter(keys[4]), .edit_start(keys[5]), .edit_ch(1'b0),
        .edit_hys(keys[6]), .edit_direct(edit_direct), .menu_code(code), .edit_active(edit_active),
        .edit_digit(edit_digit), .edit_value(edit_value), .alarm_out(alarm_out), .annunciator(annunciator),
        .show_tag(show_tag));
    dsau_load i_dsau_load (.contact(alarm_out), .load_on(load_on));
    initial
    begin
        forever #50 pclk = ~pclk;
    end
    function automatic logic [31:0] rbcd(input int nd);
        logic [31:0] v;
        v = 32'h0;
        for (int i = 0; i < nd; i++)
        begin
            v[i*4+:4] = 4'(unsigned'($random(seed)) % 10);
        end
        return v;
    endfunction : rbcd
    function automatic logic [31:0] rv(input logic [3:0] k);
        return {sp[31:12], k, sp[7:0]};
    endfunction : rv
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(rd, x)
    endtask : rc
    task automatic wst(input logic [7:0] a, input logic [3:0] s);
        n = 0;
        apb(1'b0, a, 32'h0);
        while (rd[3:0] !== s && n < 100)
        begin
            apb(1'b0, a, 32'h0);
            n++;
        end
        if (n >= 100)
        begin
            failures++;
        end
    endtask : wst
    task automatic key(input logic [6:0] m);
        keys <= m;
        @(posedge pclk);
        keys <= 7'h00;
        repeat (2) @(posedge pclk);
    endtask : key
    task automatic toggles(input logic sel, input int c);
        logic [1:0] s;
        s = 2'b00;
        repeat (2 * TK)
        begin
            @(posedge pclk);
            s[sel ? show_tag[c] : annunciator[c]] = 1'b1;
        end
        `CHK(s, 2'b11)
    endtask : toggles
    task automatic give_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (20000) @(posedge pclk);
        failures++;
        give_verdict();
    end
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc(8'h00, 32'h0);
        rc(8'h34, 32'h1);
        `CHK(alarm_out, 2'b00)
        apb(1'b0, 8'h18, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
        apb(1'b1, 8'h04, 32'h0099_9999);
        apb(1'b1, 8'h04, 32'h0100_0000);
        rc(8'h04, 32'h0099_9999);
        apb(1'b1, 8'h00, 32'h2);
        rc(8'h04, 32'h0);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h20, 32'h1f);
        rc(8'h20, 32'h2);
        apb(1'b1, 8'h24, 32'h9999_9999);
        rc(8'h24, 32'h9999_9999);
        apb(1'b1, 8'h28, 32'h100);
        rc(8'h28, 32'h0);
        $display("register test done");
        sp = rbcd(6);
        sp[11:8] = 4'h5;
        rate_v <= rv(4'h4);
        apb(1'b1, 8'h04, sp);
        apb(1'b1, 8'h08, 32'h100);
        apb(1'b1, 8'h00, 32'h19);
        wst(8'h14, 4'h1);
        `CHK(load_on[0], 1'b1)
        rate_v <= rv(4'h5);
        wst(8'h14, 4'h4);
        `CHK({alarm_out[0], annunciator[0]}, 2'b01)
        toggles(1'b1, 0);
        rate_v <= rv(4'h4);
        repeat (4 * TK) @(posedge pclk);
        wst(8'h14, 4'h4);
        `CHK(rd[3:0], 4'h4)
        rate_v <= rv(4'h3);
        wst(8'h14, 4'h1);
        `CHK(rd[3:0], 4'h1)
        $display("high rate test done");
        rate_v <= rv(4'h7);
        tv = rbcd(8);
        tot_v <= tv;
        apb(1'b1, 8'h00, 32'h05);
        apb(1'b1, 8'h24, tv);
        apb(1'b1, 8'h20, 32'h3);
        wst(8'h34, 4'h4);
        `CHK(rd[3:0], 4'h4)
        rate_v <= rv(4'h5);
        wst(8'h14, 4'h4);
        `CHK(alarm_out, 2'b11)
        rate_v <= rv(4'h6);
        repeat (4 * TK) @(posedge pclk);
        wst(8'h14, 4'h4);
        `CHK(rd[3:0], 4'h4)
        rate_v <= rv(4'h7);
        wst(8'h14, 4'h1);
        `CHK(rd[3:0], 4'h1)
        apb(1'b1, 8'h20, 32'h2);
        rc(8'h24, tv);
        $display("low and total test done");
        rate_v <= rv(4'h3);
        apb(1'b1, 8'h0c, 32'h4);
        apb(1'b1, 8'h00, 32'h1);
        rate_v <= rv(4'h5);
        wst(8'h14, 4'h2);
        `CHK(alarm_out[0], 1'b0)
        toggles(1'b0, 0);
        wst(8'h14, 4'h4);
        `CHK(n >= 6, 1'b1)
        `CHK({alarm_out[0], annunciator[0]}, 2'b11)
        rate_v <= rv(4'h3);
        wst(8'h14, 4'h1);
        rate_v <= rv(4'h5);
        wst(8'h14, 4'h2);
        rate_v <= rv(4'h3);
        wst(8'h14, 4'h1);
        `CHK({rd[3:0], annunciator[0]}, 5'h02)
        $display("delay test done");
        apb(1'b1, 8'h0c, 32'h0);
        rate_v <= rv(4'h5);
        wst(8'h14, 4'h4);
        key(7'h01);
        rc(8'h14, rd);
        apb(1'b1, 8'h10, 32'h3);
        key(7'h01);
        wst(8'h14, 4'h8);
        `CHK({rd[3:0], alarm_out[0]}, 5'h10)
        toggles(1'b0, 0);
        wst(8'h14, 4'h4);
        `CHK(rd[3:0], 4'h4)
        $display("silence test done");
        key(7'h20);
        `CHK({edit_active, edit_value}, {1'b1, sp})
        key(7'h02);
        key(7'h02);
        key(7'h04);
        key(7'h08);
        `CHK(edit_digit, 3'h1)
        key(7'h10);
        e = sp;
        e[3:0] = (sp[3:0] == 4'h9) ? 4'h0 : sp[3:0] + 4'h1;
        rc(8'h04, e);
        edit_direct <= 1'b1;
        key(7'h20);
        `CHK(edit_active, 1'b0)
        apb(1'b1, 8'h40, 32'h1234_0001);
        code <= 16'h4321;
        key(7'h20);
        `CHK(edit_active, 1'b0)
        code <= 16'h1234;
        key(7'h20);
        `CHK(edit_active, 1'b1)
        key(7'h10);
        $display("editor test done");
        give_verdict();
    end
endmodule : tb_top
